// ### hw/ddr_module_access_regs.svh
// Constants for the registered DDR module access block
`ifndef DDR_MODULE_ACCESS_REGS_SVH
`define DDR_MODULE_ACCESS_REGS_SVH

// ----------------------------------------
// Command codes as {ras_n, cas_n, we_n}
// ----------------------------------------
`define CMD_MRS 3'h0
`define CMD_REFRESH 3'h1
`define CMD_PRECHARGE 3'h2
`define CMD_ACTIVE 3'h3
`define CMD_WRITE 3'h4
`define CMD_READ 3'h5

// ----------------------------------------
// Mode register fields and values
// ----------------------------------------
`define MR_RESET 14'h0022
`define MR_DLL_RST_BIT 1
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define CL_CODE_2P5 3'h6
`define LAT_HALF_2 4'h4
`define LAT_HALF_2P5 4'h5
`define AP_BIT 10
`define MRS_BANK 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define AP_TIME_NS 20
`define AP_CYCLES (((`AP_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

// ----------------------------------------
// Presence-detect store
// ----------------------------------------
`define PD_DEV_TYPE 4'hA
`define PD_DEPTH 256

`endif

// ### hw/ddr_module_access_pkg.sv
// Types shared by the registered DDR module access block
package ddr_module_access_pkg;

    // ----------------------------------------
    // Command word as seen at the pins
    // ----------------------------------------
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [13:0] a;
    } cmd_t;

    // Mode register, bit order matches address A13..A0
    typedef struct packed {
        logic [6:0] op;
        logic [2:0] cl;
        logic bt;
        logic [2:0] bl;
    } mode_t;

    typedef enum logic [3:0] {
        PD_IDLE = 4'h0,
        PD_ADDR = 4'h1,
        PD_ACK_A = 4'h2,
        PD_WADDR = 4'h3,
        PD_ACK_W = 4'h4,
        PD_WDATA = 4'h5,
        PD_ACK_D = 4'h6,
        PD_RDATA = 4'h7,
        PD_RACK = 4'h8
    } pd_state_t;

endpackage : ddr_module_access_pkg

// ### hw/module_presence_detect_store.sv
// Two-wire presence-detect byte store of the memory module
`timescale 1ns/1ns
`include "ddr_module_access_regs.svh"

module module_presence_detect_store
    import ddr_module_access_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Already synchronised bus lines
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] presence_detect_address_select_i,
    // Open-drain data drive
    output logic sda_o,
    output logic sda_oe_o
);

    logic [7:0] mem [`PD_DEPTH];
    pd_state_t state_reg;
    logic scl_q;
    logic sda_q;
    logic [7:0] sh_reg;
    logic [3:0] bit_reg;
    logic [7:0] ptr_reg;
    logic rd_reg;

    wire scl_rise = scl_i & ~scl_q;
    wire scl_fall = ~scl_i & scl_q;
    wire start_w = scl_i & scl_q & sda_q & ~sda_i;
    wire stop_w = scl_i & scl_q & ~sda_q & sda_i;
    wire [7:0] sh_in = {sh_reg[6:0], sda_i};
    wire addr_hit = sh_reg[7:1] ==
        {`PD_DEV_TYPE, presence_detect_address_select_i};
    wire full_w = bit_reg == 4'h8;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_o <= 1'b0;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            sda_o <= 1'b0;
        end
    end

    // No write-protect input: hardware protection is always off
    always_ff @(posedge clk_sys_i) begin
        if (state_reg == PD_WDATA && scl_fall && full_w) begin
            mem[ptr_reg] <= sh_reg;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= PD_IDLE;
            sh_reg <= 8'h00;
            bit_reg <= 4'h0;
            ptr_reg <= 8'h00;
            rd_reg <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (start_w) begin
            state_reg <= PD_ADDR;
            bit_reg <= 4'h0;
            sda_oe_o <= 1'b0;
        end else if (stop_w) begin
            state_reg <= PD_IDLE;
            sda_oe_o <= 1'b0;
        end else if (scl_rise) begin
            case (state_reg)
                PD_ADDR, PD_WADDR, PD_WDATA: begin
                    sh_reg <= sh_in;
                    bit_reg <= bit_reg + 4'h1;
                end
                PD_RACK: begin
                    if (sda_i) begin
                        state_reg <= PD_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                PD_ADDR: begin
                    if (full_w && addr_hit) begin
                        state_reg <= PD_ACK_A;
                        rd_reg <= sh_reg[0];
                        sda_oe_o <= 1'b1;
                    end else if (full_w) begin
                        state_reg <= PD_IDLE;
                    end
                end
                PD_WADDR, PD_WDATA: begin
                    if (full_w) begin
                        state_reg <= state_reg == PD_WADDR ?
                            PD_ACK_W : PD_ACK_D;
                        sda_oe_o <= 1'b1;
                        if (state_reg == PD_WADDR) begin
                            ptr_reg <= sh_reg;
                        end else begin
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                    end
                end
                PD_ACK_A, PD_RACK: begin
                    bit_reg <= 4'h0;
                    if (state_reg == PD_ACK_A && !rd_reg) begin
                        state_reg <= PD_WADDR;
                        sda_oe_o <= 1'b0;
                    end else begin
                        state_reg <= PD_RDATA;
                        sh_reg <= mem[ptr_reg];
                        ptr_reg <= ptr_reg + 8'h01;
                        bit_reg <= 4'h1;
                        sda_oe_o <= ~mem[ptr_reg][7];
                    end
                end
                PD_ACK_W, PD_ACK_D: begin
                    state_reg <= PD_WDATA;
                    bit_reg <= 4'h0;
                    sda_oe_o <= 1'b0;
                end
                PD_RDATA: begin
                    if (full_w) begin
                        state_reg <= PD_RACK;
                        sda_oe_o <= 1'b0;
                    end else begin
                        sda_oe_o <= ~sh_reg[3'h7 - bit_reg[2:0]];
                        bit_reg <= bit_reg + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

endmodule : module_presence_detect_store

// ### hw/ddr_module_access.sv
// Registered DDR memory module: command, burst and data path
`timescale 1ns/1ns
`include "ddr_module_access_regs.svh"


module ddr_module_access
    import ddr_module_access_pkg::*;
#(
    parameter int DQ_W = 8,
    parameter int COL_W = 10,
    parameter int ROW_BITS = 2
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Differential link clock
    input wire logic ck_i,
    input wire logic ck_n_i,
    // Command and address
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [1:0] ba_i,
    input wire logic [13:0] addr_i,
    // Data and strobe
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic dqs_i,
    output logic dqs_o,
    output logic dqs_oe_o,
    // Presence-detect two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [2:0] presence_detect_address_select_i,
    // Status
    output logic [3:0] bank_open_o,
    output logic burst_active_o,
    output logic [2:0] read_latency_setting_o,
    output logic dll_reset_o
);

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (DQ_W < 1 || COL_W < 3 || COL_W > 10 ||
        ROW_BITS < 1 || ROW_BITS > 14) begin : g_chk
        $error("ddr_module_access: unsupported parameters");
    end

    localparam int PW = DQ_W + 28;
    localparam int AW = 2 + ROW_BITS + COL_W;
    localparam int DEPTH = 1 << AW;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [PW-1:0] sync1_reg;
    logic [PW-1:0] sync2_reg;
    logic scl_s;
    logic sda_s;
    logic [2:0] sa_s;
    logic ck_s;
    logic ckn_s;
    logic dqs_s;
    logic [DQ_W-1:0] dq_s;
    cmd_t pin_cmd;

    wire [PW-1:0] pin_w = {scl_i, sda_i,
        presence_detect_address_select_i, ck_i, ck_n_i, dqs_i, dq_i,
        cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i};

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pin_w;
            sync2_reg <= sync1_reg;
        end
    end

    assign {scl_s, sda_s, sa_s, ck_s, ckn_s, dqs_s, dq_s, pin_cmd} =
        sync2_reg;

    // ----------------------------------------
    // Link clock and strobe edges
    // ----------------------------------------
    logic ck_pos_q;
    logic dqs_q;

    // Positive crossing: true high while complement low
    wire ck_pos_w = ck_s & ~ckn_s;
    wire ck_rise = ck_pos_w & ~ck_pos_q;
    wire ck_fall = ~ck_pos_w & ck_pos_q;
    wire ck_edge = ck_rise | ck_fall;
    wire dqs_edge = dqs_s ^ dqs_q;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ck_pos_q <= 1'b0;
            dqs_q <= 1'b0;
        end else begin
            ck_pos_q <= ck_pos_w;
            dqs_q <= dqs_s;
        end
    end

    // ----------------------------------------
    // Module command register
    // ----------------------------------------
    cmd_t cmd_reg;

    // Memory devices act on last rise's capture: one clock late
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_reg <= '{cs_n: 1'b1, default: '0};
        end else if (ck_rise) begin
            cmd_reg <= pin_cmd;
        end
    end

    wire cmd_v = ck_rise & ~cmd_reg.cs_n;
    wire [2:0] op_w = {cmd_reg.ras_n, cmd_reg.cas_n, cmd_reg.we_n};
    wire is_act = cmd_v && op_w == `CMD_ACTIVE;
    wire is_rd = cmd_v && op_w == `CMD_READ;
    wire is_wr = cmd_v && op_w == `CMD_WRITE;
    wire is_pre = cmd_v && op_w == `CMD_PRECHARGE;
    wire is_mrs = cmd_v && op_w == `CMD_MRS;

    // ----------------------------------------
    // Mode register
    // ----------------------------------------
    mode_t mode_reg;

    // Only memory array writes touch storage, never this path
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_reg <= `MR_RESET;
        end else if (is_mrs && cmd_reg.ba == `MRS_BANK) begin
            mode_reg <= cmd_reg.a;
        end else if (ck_rise) begin
            mode_reg.op[`MR_DLL_RST_BIT] <= 1'b0;
        end
    end

    logic [3:0] bl_len_w;
    always_comb begin
        case (mode_reg.bl)
            `BL_CODE_2: bl_len_w = 4'h2;
            `BL_CODE_4: bl_len_w = 4'h4;
            `BL_CODE_8: bl_len_w = 4'h8;
            default: bl_len_w = 4'h8;
        endcase
    end

    // Any setting other than 2.5 runs as latency two
    wire [3:0] lat_w = mode_reg.cl == `CL_CODE_2P5 ?
        `LAT_HALF_2P5 : `LAT_HALF_2;

    // ----------------------------------------
    // Banks
    // ----------------------------------------
    logic open_reg [4];
    logic [13:0] row_reg [4];
    logic ap_close;
    logic [1:0] ap_bank_reg;

    for (genvar b = 0; b < 4; b++) begin : g_bank
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                open_reg[b] <= 1'b0;
                row_reg[b] <= 14'h0000;
            end else if (is_act && cmd_reg.ba == 2'(b)) begin
                open_reg[b] <= 1'b1;
                row_reg[b] <= cmd_reg.a;
            end else if (is_pre && (cmd_reg.a[`AP_BIT] ||
                         cmd_reg.ba == 2'(b))) begin
                open_reg[b] <= 1'b0;
            end else if (ap_close && ap_bank_reg == 2'(b)) begin
                open_reg[b] <= 1'b0;
            end
        end
    end

    assign bank_open_o = {open_reg[3], open_reg[2],
        open_reg[1], open_reg[0]};

    // ----------------------------------------
    // Burst engine
    // ----------------------------------------
    logic bst_wr_reg;
    logic bst_ap_reg;
    logic [1:0] bst_bank_reg;
    logic [COL_W-1:0] bst_col_reg;
    logic [3:0] bst_len_reg;
    logic bst_bt_reg;
    logic [3:0] cnt_reg;
    logic [3:0] beat_reg;
    logic [1:0] ap_cnt_reg;

    // Accesses to a closed bank are dropped
    wire start_w = (is_rd || is_wr) &&
        open_reg[cmd_reg.ba];
    wire [3:0] t_w = cnt_reg + 4'h1;
    wire [3:0] rbeat_w = t_w - lat_w;
    wire rd_run = burst_active_o && !bst_wr_reg;
    wire rd_out = t_w >= lat_w;
    wire rd_done = rd_run && ck_edge && rd_out &&
        rbeat_w == bst_len_reg;
    wire wr_cap = burst_active_o && bst_wr_reg && dqs_edge;
    wire wr_done = wr_cap && beat_reg == bst_len_reg - 4'h1;
    wire done_w = rd_done || wr_done;
    wire [2:0] mask_w = 3'(bst_len_reg - 4'h1);

    function automatic logic [COL_W-1:0] col_at(
        input logic [COL_W-1:0] st,
        input logic [2:0] k,
        input logic [2:0] m,
        input logic bt
    );
        logic [2:0] lo;
        lo = bt ? (st[2:0] ^ k) : (st[2:0] + k);
        col_at = st;
        col_at[2:0] = (st[2:0] & ~m) | (lo & m);
    endfunction : col_at

    wire [ROW_BITS-1:0] row_w = row_reg[bst_bank_reg][ROW_BITS-1:0];
    wire [AW-1:0] rd_a0 = {bst_bank_reg, row_w,
        col_at(bst_col_reg, rbeat_w[2:0], mask_w, bst_bt_reg)};
    wire [AW-1:0] rd_a1 = {bst_bank_reg, row_w,
        col_at(bst_col_reg, rbeat_w[2:0] + 3'h1, mask_w, bst_bt_reg)};
    wire [AW-1:0] wr_a0 = {bst_bank_reg, row_w,
        col_at(bst_col_reg, beat_reg[2:0] - 3'h1, mask_w, bst_bt_reg)};
    wire [AW-1:0] wr_a1 = {bst_bank_reg, row_w,
        col_at(bst_col_reg, beat_reg[2:0], mask_w, bst_bt_reg)};

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            burst_active_o <= 1'b0;
            bst_wr_reg <= 1'b0;
            bst_ap_reg <= 1'b0;
            bst_bank_reg <= 2'h0;
            bst_col_reg <= '0;
            bst_len_reg <= 4'h2;
            bst_bt_reg <= 1'b0;
            cnt_reg <= 4'h0;
            beat_reg <= 4'h0;
        end else if (start_w) begin
            burst_active_o <= 1'b1;
            bst_wr_reg <= is_wr;
            bst_ap_reg <= cmd_reg.a[`AP_BIT];
            bst_bank_reg <= cmd_reg.ba;
            bst_col_reg <= cmd_reg.a[COL_W-1:0];
            bst_len_reg <= bl_len_w;
            bst_bt_reg <= mode_reg.bt;
            cnt_reg <= 4'h0;
            beat_reg <= 4'h0;
        end else if (done_w) begin
            burst_active_o <= 1'b0;
        end else if (rd_run && ck_edge) begin
            cnt_reg <= t_w;
        end else if (wr_cap) begin
            beat_reg <= beat_reg + 4'h1;
        end
    end

    // Self-timed precharge once the last beat is gone
    assign ap_close = ap_cnt_reg == 2'h1;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ap_cnt_reg <= 2'h0;
            ap_bank_reg <= 2'h0;
        end else if (done_w && bst_ap_reg) begin
            ap_cnt_reg <= 2'(`AP_CYCLES);
            ap_bank_reg <= bst_bank_reg;
        end else if (ap_cnt_reg != 2'h0) begin
            ap_cnt_reg <= ap_cnt_reg - 2'h1;
        end
    end

    // ----------------------------------------
    // Memory array and write capture
    // ----------------------------------------
    logic [DQ_W-1:0] mem [DEPTH];
    logic [DQ_W-1:0] wr_lo_reg;
    logic [DQ_W-1:0] rd_hi_reg;

    // Pairs commit together as one double-width core write
    always_ff @(posedge clk_sys_i) begin
        if (wr_cap && beat_reg[0]) begin
            mem[wr_a0] <= wr_lo_reg;
            mem[wr_a1] <= dq_s;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_lo_reg <= '0;
        end else if (wr_cap && !beat_reg[0]) begin
            wr_lo_reg <= dq_s;
        end
    end

    // ----------------------------------------
    // Read drive
    // ----------------------------------------
    wire pre_w = rd_run && ck_edge && t_w == lat_w - 4'h2;
    wire beat_w = rd_run && ck_edge && rd_out &&
        rbeat_w < bst_len_reg;

    // Write strobe comes from the controller: never drive it then
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dqs_oe_o <= 1'b0;
            dqs_o <= 1'b0;
            dq_oe_o <= 1'b0;
        end else if (pre_w) begin
            dqs_oe_o <= 1'b1;
            dqs_o <= 1'b0;
        end else if (beat_w) begin
            dqs_oe_o <= 1'b1;
            dqs_o <= ~rbeat_w[0];
            dq_oe_o <= 1'b1;
        end else if (rd_done || start_w) begin
            dqs_oe_o <= 1'b0;
            dqs_o <= 1'b0;
            dq_oe_o <= 1'b0;
        end
    end

    // Data changes on the same clock edge as the strobe
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dq_o <= '0;
            rd_hi_reg <= '0;
        end else if (beat_w && rbeat_w[0]) begin
            dq_o <= rd_hi_reg;
        end else if (beat_w) begin
            dq_o <= mem[rd_a0];
            rd_hi_reg <= mem[rd_a1];
        end
    end

    // ----------------------------------------
    // Status
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            read_latency_setting_o <= 3'h0;
            dll_reset_o <= 1'b0;
        end else begin
            read_latency_setting_o <= mode_reg.cl;
            dll_reset_o <= mode_reg.op[`MR_DLL_RST_BIT];
        end
    end

    // ----------------------------------------
    // Presence-detect store
    // ----------------------------------------
    module_presence_detect_store u_pd (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .scl_i(scl_s),
        .sda_i(sda_s),
        .presence_detect_address_select_i(sa_s),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o)
    );

endmodule : ddr_module_access

// ### test/ddr_module_access_chk.sv
// Port assertions for the registered DDR module access block
`timescale 1ns/1ns
module ddr_module_access_chk #(parameter int DQ_W = 8) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [DQ_W-1:0] dq_o,
    input wire logic dq_oe_o,
    input wire logic dqs_o,
    input wire logic dqs_oe_o,
    input wire logic sda_o,
    input wire logic [3:0] bank_open_o,
    input wire logic burst_active_o,
    input wire logic dll_reset_o
);
    int oe_n;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            oe_n <= 0;
        else
            oe_n <= dq_oe_o ? oe_n + 1 : 0;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    AST_STROBE_WITH_DATA:
        assert property (dq_oe_o |-> dqs_oe_o) else $error("no strobe");
    AST_DATA_IN_BURST:
        assert property (dq_oe_o |-> burst_active_o) else $error("no burst");
    AST_EDGE_ALIGNED:
        assert property (dq_oe_o && $past(dq_oe_o) && $changed(dq_o)
            |-> $changed(dqs_o)) else $error("dq off edge");
    AST_PREAMBLE:
        assert property ($rose(dq_oe_o) |-> dqs_o && !$past(dqs_o)
            && $past(dqs_oe_o, 4)) else $error("bad preamble");
    AST_BURST_BOUND:
        assert property (oe_n <= 34) else $error("burst too long");
    AST_OPEN_BANK:
        assert property ($rose(burst_active_o) |-> bank_open_o != 4'h0)
            else $error("burst on closed bank");
    AST_DLL_CLEAR:
        assert property ($rose(dll_reset_o) |-> ##[1:16] !dll_reset_o)
            else $error("dll bit stuck");
    AST_SDA_OPEN_DRAIN:
        assert property (!sda_o) else $error("sda high");
    cover property ($rose(dq_oe_o));
    cover property (burst_active_o && !dqs_oe_o);
    cover property ($fell(dll_reset_o));
endmodule : ddr_module_access_chk

bind ddr_module_access ddr_module_access_chk #(.DQ_W(DQ_W)) u_chk (
    .clk_sys_i, .sys_rst_i, .dq_o, .dq_oe_o, .dqs_o, .dqs_oe_o,
    .sda_o, .bank_open_o, .burst_active_o, .dll_reset_o
);

// ### test/ddr_host_model.sv
// Host controller model: link clock, commands and write bursts
`timescale 1ns/1ns
module ddr_host_model
    import ddr_module_access_pkg::*;
(
    output logic ck_o,
    output logic ck_n_o,
    output cmd_t cmd_o,
    output logic [7:0] dq_o,
    output logic dq_oe_o,
    output logic dqs_o,
    output logic dqs_oe_o
);
    assign ck_n_o = ~ck_o;
    initial begin
        {ck_o, dq_oe_o, dqs_o, dqs_oe_o, dq_o} = 12'h000;
        cmd_o = '1;
        #37;
        forever #400 ck_o = ~ck_o;
    end
    // Held a whole link period; released lines show inverse
    task automatic issue(input cmd_t c);
        @(negedge ck_o);
        cmd_o <= c;
        @(negedge ck_o);
        cmd_o <= {1'b1, ~c[18:0]};
    endtask : issue
    // Data moves on link edges, strobe mid-beat
    task automatic write_beats(input logic [7:0] d [$]);
        dqs_oe_o <= 1'b1;
        @(posedge ck_o);
        @(negedge ck_o);
        foreach (d[k]) begin
            dq_oe_o <= 1'b1;
            dq_o <= d[k];
            #200 dqs_o <= ~dqs_o;
            #200;
        end
        dq_oe_o <= 1'b0;
        dqs_oe_o <= 1'b0;
    endtask : write_beats
endmodule : ddr_host_model

// ### test/tb_top.sv
// Self-checking bench for the registered DDR module access block
`timescale 1ns/1ns
`include "ddr_module_access_regs.svh"
module tb_top
    import ddr_module_access_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] sel = 3'h0;
    logic scl_m = 1'b1, sda_m = 1'b1;
    logic h_ck, h_ck_n, h_dq_oe, h_dqs, h_dqs_oe;
    cmd_t h_cmd;
    logic [7:0] h_dq, dq_o, dq_pat = 8'h00;
    logic dq_oe_o, dqs_o, dqs_oe_o, sda_oe_o, dqs_pat = 1'b0;
    logic oe_q = 1'b0, dqs_q = 1'b0;
    logic [3:0] bank_open_o;
    logic [2:0] read_latency_setting_o;
    logic [7:0] mem [int];
    logic [7:0] rd_q [$];
    int n_mismatch = 0, checks = 0, cyc = 0;
    wire [7:0] dq_w = h_dq_oe ? h_dq : (dq_oe_o ? dq_o : dq_pat);
    wire dqs_w = h_dqs_oe ? h_dqs : (dqs_oe_o ? dqs_o : dqs_pat);
    // Open-drain data line: either side may pull it low
    wire sda_w = sda_m & ~sda_oe_o;
    always #50 clk_sys_i = ~clk_sys_i;
    ddr_host_model u_host (
        .ck_o(h_ck), .ck_n_o(h_ck_n), .cmd_o(h_cmd), .dq_o(h_dq),
        .dq_oe_o(h_dq_oe), .dqs_o(h_dqs), .dqs_oe_o(h_dqs_oe)
    );
    ddr_module_access u_dut (
        .clk_sys_i, .sys_rst_i, .ck_i(h_ck), .ck_n_i(h_ck_n),
        .cs_n_i(h_cmd.cs_n), .ras_n_i(h_cmd.ras_n),
        .cas_n_i(h_cmd.cas_n), .we_n_i(h_cmd.we_n), .ba_i(h_cmd.ba),
        .addr_i(h_cmd.a), .dq_i(dq_w), .dq_o, .dq_oe_o, .dqs_i(dqs_w),
        .dqs_o, .dqs_oe_o, .scl_i(scl_m), .sda_i(sda_w), .sda_o(),
        .sda_oe_o, .presence_detect_address_select_i(sel),
        .bank_open_o, .burst_active_o(), .read_latency_setting_o,
        .dll_reset_o()
    );
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic cmp(input string what, input logic [7:0] exp, got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %0h got %0h", what, exp, got);
        end
    endtask : cmp
    task automatic cmd(input logic [2:0] c, input int b, int a);
        u_host.issue({1'b0, c, 2'(b), 14'(a)});
    endtask : cmd
    // One two-wire bit: data moves only while the clock is low
    task automatic pd_bit(input logic v, output logic got);
        sda_m <= v;
        repeat (5) @(negedge clk_sys_i);
        scl_m <= 1'b1;
        repeat (5) @(negedge clk_sys_i);
        got = sda_w;
        scl_m <= 1'b0;
    endtask : pd_bit
    // Eight bits and the acknowledge slot, first bit highest
    task automatic pd_byte(input logic [8:0] v, output logic [8:0] got);
        for (int j = 8; j >= 0; j--)
            pd_bit(v[j], got[j]);
    endtask : pd_byte
    // Start condition, or stop when asked
    task automatic pd_edge(input logic stop);
        sda_m <= ~stop;
        repeat (5) @(negedge clk_sys_i);
        scl_m <= 1'b1;
        repeat (5) @(negedge clk_sys_i);
        sda_m <= stop;
        repeat (5) @(negedge clk_sys_i);
        if (!stop)
            scl_m <= 1'b0;
    endtask : pd_edge
    function automatic int adr(int b, int row, int s, int k, int n, int t);
        return (b << 12) | ((row & 3) << 10) | (s & ~(n - 1))
            | ((t ? (s ^ k) : (s + k)) & (n - 1));
    endfunction : adr
    // Idle lines toggle so a stale value never looks valid
    always @(negedge clk_sys_i) begin
        dq_pat <= ~dq_w;
        dqs_pat <= ~dqs_w;
        if (dq_oe_o && (!oe_q || dqs_o != dqs_q))
            rd_q.push_back(dq_o);
        oe_q <= dq_oe_o;
        dqs_q <= dqs_o;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        int n, s, r, b, t, row, k;
        logic [2:0] cl;
        logic [7:0] d [$];
        logic [8:0] g;
        void'($urandom(32'hCFF14277));
        sel = 3'($urandom);
        repeat (20) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        cmp("latency", 8'h2, 8'(read_latency_setting_o));
        for (int i = 0; i < 12; i++) begin
            n = 2 << (i % 3);
            t = i / 3 % 2;
            b = i % 4;
            cl = i < 6 ? 3'h2 : `CL_CODE_2P5;
            // Banks all closed here, so a mode load is legal
            cmd(`CMD_MRS, `MRS_BANK, {i == 0, 1'b0, cl, 1'(t),
                3'(i % 3 + 1)});
            repeat (16) @(negedge clk_sys_i);
            cmp("latency", 8'(cl), 8'(read_latency_setting_o));
            row = $urandom;
            cmd(`CMD_ACTIVE, b, row);
            cmp("early", 8'h0, 8'(bank_open_o));
            cmd(`CMD_REFRESH, 0, 0);
            repeat (12) @(negedge clk_sys_i);
            cmp("open", 8'(1 << b), 8'(bank_open_o));
            s = $urandom % 1024;
            d.delete();
            for (k = 0; k < n; k++) begin
                d.push_back(8'($urandom));
                mem[adr(b, row, s, k, n, t)] = d[k];
            end
            cmd(`CMD_WRITE, b, s);
            u_host.write_beats(d);
            cmp("kept", 8'(1 << b), 8'(bank_open_o));
            r = (s & ~(n - 1)) | ($urandom % n);
            rd_q.delete();
            cmd(`CMD_READ, b, r | 1024);
            k = 0;
            while ((rd_q.size() < n || dq_oe_o !== 1'b0) && k < 300) begin
                @(negedge clk_sys_i);
                k++;
            end
            cmp("beats", 8'(n), 8'(rd_q.size()));
            for (k = 0; k < n && k < rd_q.size(); k++)
                cmp("beat", mem[adr(b, row, r, k, n, t)], rd_q[k]);
            repeat (4) @(negedge clk_sys_i);
            cmp("closed", 8'h0, 8'(bank_open_o));
            $display("test %0d done", i);
        end
        s = $urandom;
        r = $urandom;
        pd_edge(1'b0);
        pd_byte({`PD_DEV_TYPE, sel, 1'b0, 1'b1}, g);
        cmp("pd ack", 8'h0, 8'(g[0]));
        pd_byte({8'(s), 1'b1}, g);
        pd_byte({8'(r), 1'b1}, g);
        pd_edge(1'b1);
        pd_edge(1'b0);
        pd_byte({`PD_DEV_TYPE, sel, 1'b0, 1'b1}, g);
        pd_byte({8'(s), 1'b1}, g);
        pd_edge(1'b0);
        pd_byte({`PD_DEV_TYPE, sel, 1'b1, 1'b1}, g);
        pd_byte(9'h1FF, g);
        cmp("pd byte", 8'(r), g[8:1]);
        pd_edge(1'b1);
        $display("test presence store done");
        cmd(`CMD_MRS, 1, 34);
        repeat (16) @(negedge clk_sys_i);
        cmp("ignored", 8'h6, 8'(read_latency_setting_o));
        complete_run();
    end
endmodule : tb_top
